// >>> core/qrcm_pkg.sv
package qrcm_pkg;
   // Opcodes handled by this block
   localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
   localparam logic [7:0] OP_QUAD_IO = 8'heb;
   localparam logic [7:0] OP_DUAL_IO = 8'hbb;
   localparam logic [7:0] OP_MODE_RST = 8'hff;
   // Mode byte: reset value keeps bit 4 set, so continuous mode is off
   localparam logic [7:0] MODE_RST_VAL = 8'hff;
   localparam int MODE_SEL_LO = 4;
   localparam int MODE_SEL_HI = 5;
   localparam int MODE_RST_BIT = 4;
   localparam logic [1:0] CONT_SEL = 2'h2;
   // Phase lengths in bits (address, mode) or in link clocks (opcode, dummy)
   localparam logic [4:0] CMD_CLKS = 5'h08;
   localparam logic [4:0] ADDR_BITS = 5'h18;
   localparam logic [4:0] MODE_BITS = 5'h08;
   localparam logic [4:0] QOUT_DUMMY_CLKS = 5'h08;
   localparam logic [4:0] QIO_DUMMY_CLKS = 5'h04;
   // Lane width as log2 of bits per clock
   localparam logic [1:0] WL_SINGLE = 2'h0;
   localparam logic [1:0] WL_DUAL = 2'h1;
   localparam logic [1:0] WL_QUAD = 2'h2;
   // Synchroniser reset values: select idles high
   localparam logic [2:0] CS_SYNC_RST = 3'h7;
   localparam logic [2:0] SCLK_SYNC_RST = 3'h0;
   localparam logic [3:0] DIN_SYNC_RST = 4'h0;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_CMD = 7'h02,
      ST_ADDR = 7'h04,
      ST_MODE = 7'h08,
      ST_DUMMY = 7'h10,
      ST_DATA = 7'h20,
      ST_IGNORE = 7'h40
   } qrcm_state_t;
endpackage

// >>> core/qrcm_core.sv
`timescale 1ns/100ps
// Behaviour
// R1: Quad-output read needs quad enable bit
// R2: Host sends 6Bh, address, dummy byte
// R3: Quad data MSB on line 3, two clocks
// R4: Read address increments, wraps to zero
// R5: Select high ends read, releases lines
// R6: Host sends EBh, quad address, mode
// R7: Quad-I/O data after mode, two dummies
// R8: Quad-I/O read needs quad enable bit
// R9: Mode pair 10 skips next opcode
// R10: Other mode pair restores full opcode
// R11: Reserved mode bits are ignored
// R12: Host releases lines before first data
// R13: Dual and quad I/O capture mode byte
// R14: All-ones instruction sets mode bit 4
// R15: Host clocks 8 or 16 ones
// R16: Host sends BBh, dual address, mode
// R17: Continuous mode off after power-up

module qrcm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_reg;
   logic [PW-1:0] rd_reg;
   logic [PW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_reg != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rd_reg];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else if (flush_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // qrcm_fifo

module qrcm_core #(
   parameter int ADDR_W = 20,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic SPI_CS_N_I,
   input wire logic SPI_SCLK_I,
   input wire logic [3:0] QUAD_DATA_LINES_I,
   output logic [3:0] QUAD_DATA_LINES_O,
   output logic [3:0] QUAD_DATA_LINES_OE_O,
   input wire logic QUAD_ENABLE_BIT_I,
   output logic MEM_RD_O,
   output logic [ADDR_W-1:0] MEM_ADDR_O,
   input wire logic MEM_VALID_I,
   input wire logic [7:0] MEM_DATA_I,
   output logic MEM_READY_O,
   output logic CONT_READ_ACTIVE_O,
   output logic [7:0] CONTINUOUS_READ_MODE_BITS_O
);
   logic [2:0] sclk_sync_reg;
   logic [2:0] cs_sync_reg;
   logic [3:0] din_s1_reg;
   logic [3:0] din_s2_reg;
   logic [3:0] din_s3_reg;
   logic sclk_lvl_reg;
   logic cs_n_lvl_reg;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   qrcm_pkg::qrcm_state_t state_reg;
   logic [4:0] bit_cnt_reg;
   logic [4:0] len_reg;
   logic [1:0] wl_reg;
   logic [1:0] cont_wl_reg;
   logic [23:0] in_sh_reg;
   logic [23:0] in_sh_next;
   logic [7:0] mode_bits_reg;
   logic cont_active;
   logic last_clk;
   logic cmd_done;
   logic mode_done;
   logic addr_done;
   logic [7:0] cmd_byte;
   logic [ADDR_W-1:0] rd_addr_reg;
   logic fetch_reg;
   logic pend_reg;
   logic drop_reg;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic fifo_pop;
   logic [2:0] slot_reg;
   logic [7:0] sh_out_reg;
   logic [3:0] dat_reg;
   logic [3:0] oe_reg;
   logic [7:0] byte_in;
   logic [3:0] hi_nib;

   // Bits per clock come in on the low lines, newest bit last
   function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] d,
                                            input logic [1:0] wl);
      logic [23:0] r;
      r = {sh[22:0], d[0]};
      if (wl == qrcm_pkg::WL_DUAL) begin
         r = {sh[21:0], d[1:0]};
      end else if (wl == qrcm_pkg::WL_QUAD) begin
         r = {sh[19:0], d};
      end
      return r;
   endfunction

   // Top bits of a byte onto the lanes of the active width
   function automatic logic [3:0] lane_map(input logic [7:0] b, input logic [1:0] wl);
      logic [3:0] r;
      r = {2'h0, b[7], 1'b0};
      if (wl == qrcm_pkg::WL_DUAL) begin
         r = {2'h0, b[7:6]};
      end else if (wl == qrcm_pkg::WL_QUAD) begin
         r = b[7:4];
      end
      return r;
   endfunction

   // Link pins pass three flops; a clock or select level counts once flops two and three agree
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         sclk_sync_reg <= qrcm_pkg::SCLK_SYNC_RST;
         cs_sync_reg <= qrcm_pkg::CS_SYNC_RST;
         din_s1_reg <= qrcm_pkg::DIN_SYNC_RST;
         din_s2_reg <= qrcm_pkg::DIN_SYNC_RST;
         din_s3_reg <= qrcm_pkg::DIN_SYNC_RST;
         sclk_lvl_reg <= 1'b0;
         cs_n_lvl_reg <= 1'b1;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], SPI_SCLK_I};
         cs_sync_reg <= {cs_sync_reg[1:0], SPI_CS_N_I};
         din_s1_reg <= QUAD_DATA_LINES_I;
         din_s2_reg <= din_s1_reg;
         din_s3_reg <= din_s2_reg;
         if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
            sclk_lvl_reg <= sclk_sync_reg[2];
         end
         if (cs_sync_reg[1] == cs_sync_reg[2]) begin
            cs_n_lvl_reg <= cs_sync_reg[2];
         end
      end
   end

   assign sclk_rise = (sclk_sync_reg[1] == sclk_sync_reg[2]) & sclk_sync_reg[2] & ~sclk_lvl_reg;
   assign sclk_fall = (sclk_sync_reg[1] == sclk_sync_reg[2]) & ~sclk_sync_reg[2] & sclk_lvl_reg;
   assign cs_fall = (cs_sync_reg[1] == cs_sync_reg[2]) & ~cs_sync_reg[2] & cs_n_lvl_reg;
   assign cs_rise = (cs_sync_reg[1] == cs_sync_reg[2]) & cs_sync_reg[2] & ~cs_n_lvl_reg;

   assign in_sh_next = shift_in(in_sh_reg, din_s3_reg, wl_reg);
   assign last_clk = sclk_rise & (bit_cnt_reg == len_reg - 5'h01);
   assign cmd_done = last_clk & (state_reg == qrcm_pkg::ST_CMD);
   assign addr_done = last_clk & (state_reg == qrcm_pkg::ST_ADDR);
   assign mode_done = last_clk & (state_reg == qrcm_pkg::ST_MODE);
   assign cmd_byte = in_sh_next[7:0];
   // Only the select pair decides; reserved mode bits never reach the decode
   assign cont_active = (mode_bits_reg[qrcm_pkg::MODE_SEL_HI:qrcm_pkg::MODE_SEL_LO]
                         == qrcm_pkg::CONT_SEL); // [R9] [R10] [R11]

   // Command sequencing on link clock edges
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state_reg <= qrcm_pkg::ST_IDLE;
         bit_cnt_reg <= 5'h00;
         len_reg <= qrcm_pkg::CMD_CLKS;
         wl_reg <= qrcm_pkg::WL_SINGLE;
         cont_wl_reg <= qrcm_pkg::WL_QUAD;
         in_sh_reg <= 24'h000000;
      end else if (cs_rise) begin
         state_reg <= qrcm_pkg::ST_IDLE; // [R5]
      end else if (cs_fall) begin
         bit_cnt_reg <= 5'h00;
         in_sh_reg <= 24'h000000;
         if (cont_active) begin
            // Address comes first, at the width of the read that armed the mode
            state_reg <= qrcm_pkg::ST_ADDR; // [R9]
            wl_reg <= cont_wl_reg;
            len_reg <= qrcm_pkg::ADDR_BITS >> cont_wl_reg;
         end else begin
            state_reg <= qrcm_pkg::ST_CMD; // [R10] [R17]
            wl_reg <= qrcm_pkg::WL_SINGLE;
            len_reg <= qrcm_pkg::CMD_CLKS;
         end
      end else if (sclk_rise) begin
         in_sh_reg <= in_sh_next;
         bit_cnt_reg <= last_clk ? 5'h00 : bit_cnt_reg + 5'h01;
         if (last_clk) begin
            unique case (state_reg)
               qrcm_pkg::ST_CMD: begin
                  state_reg <= qrcm_pkg::ST_IGNORE;
                  len_reg <= qrcm_pkg::ADDR_BITS;
                  if (cmd_byte == qrcm_pkg::OP_QUAD_OUT && QUAD_ENABLE_BIT_I) begin
                     state_reg <= qrcm_pkg::ST_ADDR; // [R1] [R2]
                     wl_reg <= qrcm_pkg::WL_SINGLE;
                  end else if (cmd_byte == qrcm_pkg::OP_QUAD_IO && QUAD_ENABLE_BIT_I) begin
                     state_reg <= qrcm_pkg::ST_ADDR; // [R8] [R6]
                     wl_reg <= qrcm_pkg::WL_QUAD;
                     cont_wl_reg <= qrcm_pkg::WL_QUAD;
                     len_reg <= qrcm_pkg::ADDR_BITS >> qrcm_pkg::WL_QUAD;
                  end else if (cmd_byte == qrcm_pkg::OP_DUAL_IO) begin
                     state_reg <= qrcm_pkg::ST_ADDR; // [R16]
                     wl_reg <= qrcm_pkg::WL_DUAL;
                     cont_wl_reg <= qrcm_pkg::WL_DUAL;
                     len_reg <= qrcm_pkg::ADDR_BITS >> qrcm_pkg::WL_DUAL;
                  end
               end
               qrcm_pkg::ST_ADDR: begin
                  if (wl_reg == qrcm_pkg::WL_SINGLE) begin
                     state_reg <= qrcm_pkg::ST_DUMMY;
                     len_reg <= qrcm_pkg::QOUT_DUMMY_CLKS;
                  end else begin
                     state_reg <= qrcm_pkg::ST_MODE;
                     len_reg <= qrcm_pkg::MODE_BITS >> wl_reg;
                  end
               end
               qrcm_pkg::ST_MODE: begin
                  if (wl_reg == qrcm_pkg::WL_QUAD) begin
                     state_reg <= qrcm_pkg::ST_DUMMY; // [R7]
                     len_reg <= qrcm_pkg::QIO_DUMMY_CLKS;
                  end else begin
                     state_reg <= qrcm_pkg::ST_DATA;
                  end
               end
               qrcm_pkg::ST_DUMMY: begin
                  // Both dummy-led reads return data on all four lines
                  state_reg <= qrcm_pkg::ST_DATA;
                  wl_reg <= qrcm_pkg::WL_QUAD; // [R3]
               end
               qrcm_pkg::ST_IDLE, qrcm_pkg::ST_DATA, qrcm_pkg::ST_IGNORE: ;
            endcase
         end
      end
   end

   // Mode byte; all-ones on line 0 in continuous mode also lands here with bit 4 set
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         mode_bits_reg <= qrcm_pkg::MODE_RST_VAL; // [R17]
      end else if (mode_done) begin
         mode_bits_reg <= in_sh_next[7:0]; // [R13] [R14]
      end else if (cmd_done && cmd_byte == qrcm_pkg::OP_MODE_RST) begin
         mode_bits_reg[qrcm_pkg::MODE_RST_BIT] <= 1'b1; // [R14]
      end
   end

   // Prefetch: one memory read in flight; a late answer after select rises is discarded
   assign MEM_RD_O = fetch_reg & ~pend_reg & ~drop_reg & fifo_in_ready & ~cs_rise;
   assign MEM_ADDR_O = rd_addr_reg;
   assign MEM_READY_O = fifo_in_ready | drop_reg;

   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rd_addr_reg <= '0;
         fetch_reg <= 1'b0;
         pend_reg <= 1'b0;
         drop_reg <= 1'b0;
      end else begin
         if (addr_done) begin
            rd_addr_reg <= in_sh_next[ADDR_W-1:0];
            fetch_reg <= 1'b1;
         end else if (MEM_RD_O) begin
            rd_addr_reg <= rd_addr_reg + 1'b1; // [R4]
         end
         if (cs_rise) begin
            fetch_reg <= 1'b0;
         end
         if (MEM_RD_O) begin
            pend_reg <= 1'b1;
         end else if (MEM_VALID_I && MEM_READY_O) begin
            pend_reg <= 1'b0;
         end
         if (cs_rise && pend_reg && !(MEM_VALID_I && MEM_READY_O)) begin
            drop_reg <= 1'b1;
         end else if (MEM_VALID_I && MEM_READY_O) begin
            drop_reg <= 1'b0;
         end
      end
   end

   qrcm_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(REF_CLK_I),
      .rst_i(SYS_RST_I),
      .flush_i(cs_rise),
      .in_valid_i(MEM_VALID_I & ~drop_reg),
      .in_ready_o(fifo_in_ready),
      .in_data_i(MEM_DATA_I),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out_data)
   );

   // Underrun sends zeros rather than stalling the link, which cannot wait
   assign byte_in = fifo_out_valid ? fifo_out_data : 8'h00;
   assign hi_nib = byte_in[7:4];
   assign fifo_pop = sclk_fall & (state_reg == qrcm_pkg::ST_DATA) & (slot_reg == 3'h0);

   // Data out on falling link edges so it is stable at the host's rising edge
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         slot_reg <= 3'h0;
         sh_out_reg <= 8'h00;
         dat_reg <= 4'h0;
         oe_reg <= 4'h0;
      end else if (cs_rise || state_reg != qrcm_pkg::ST_DATA) begin
         slot_reg <= 3'h0;
         oe_reg <= 4'h0; // [R5]
      end else if (sclk_fall) begin
         oe_reg <= lane_map(8'hff, wl_reg);
         slot_reg <= (slot_reg == 3'((8 >> wl_reg) - 1)) ? 3'h0 : slot_reg + 3'h1;
         if (slot_reg == 3'h0) begin
            dat_reg <= lane_map(byte_in, wl_reg); // [R3]
            sh_out_reg <= byte_in << (4'h1 << wl_reg);
         end else begin
            dat_reg <= lane_map(sh_out_reg, wl_reg); // [R3]
            sh_out_reg <= sh_out_reg << (4'h1 << wl_reg);
         end
      end
   end

   assign QUAD_DATA_LINES_O = dat_reg;
   assign QUAD_DATA_LINES_OE_O = oe_reg;
   assign CONT_READ_ACTIVE_O = cont_active;
   assign CONTINUOUS_READ_MODE_BITS_O = mode_bits_reg;

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);

   sequence s_quad_load;
      fifo_pop && wl_reg == qrcm_pkg::WL_QUAD;
   endsequence
   sequence s_cmd_byte(logic [7:0] op);
      cmd_done && cmd_byte == op;
   endsequence

   AST_QE_QOUT: assert property (s_cmd_byte(qrcm_pkg::OP_QUAD_OUT) |=> // [R1]
      (state_reg == qrcm_pkg::ST_ADDR) == $past(QUAD_ENABLE_BIT_I))
      else $error("quad-output read gate on quad enable wrong");
   AST_QE_QIO: assert property (s_cmd_byte(qrcm_pkg::OP_QUAD_IO) ##0 !QUAD_ENABLE_BIT_I |=> // [R8]
      state_reg == qrcm_pkg::ST_IGNORE)
      else $error("quad-I/O read ran without quad enable");
   AST_QUAD_NIBBLE: assert property (s_quad_load |=> // [R3]
      QUAD_DATA_LINES_O == $past(hi_nib) && QUAD_DATA_LINES_OE_O == 4'hf)
      else $error("quad high nibble not on lines 3..0");
   AST_WRAP: assert property (MEM_RD_O && MEM_ADDR_O == '1 |=> // [R4]
      MEM_ADDR_O == '0 || addr_done)
      else $error("read address did not wrap to zero");
   AST_CS_RELEASE: assert property (cs_rise |=> QUAD_DATA_LINES_OE_O == 4'h0 [*2]) // [R5]
      else $error("lines driven after select rose");
   AST_QIO_DUMMY: assert property (mode_done && wl_reg == qrcm_pkg::WL_QUAD |=> // [R7]
      state_reg == qrcm_pkg::ST_DUMMY && len_reg == qrcm_pkg::QIO_DUMMY_CLKS)
      else $error("quad-I/O dummy phase wrong");
   AST_CONT_SKIP: assert property (cs_fall && cont_active |=> // [R9]
      state_reg == qrcm_pkg::ST_ADDR && wl_reg == $past(cont_wl_reg))
      else $error("continuous mode did not skip opcode");
   AST_CONT_EXIT: assert property (cs_fall && !cont_active |=> // [R10]
      state_reg == qrcm_pkg::ST_CMD)
      else $error("full opcode not expected");
   AST_MODE_CAPTURE: assert property (mode_done |=> // [R13]
      mode_bits_reg == $past(in_sh_next[7:0]))
      else $error("mode byte not captured");
   AST_MODE_RST: assert property (s_cmd_byte(qrcm_pkg::OP_MODE_RST) |=> // [R14]
      mode_bits_reg[4] && !cont_active)
      else $error("mode reset did not set bit 4");
endmodule // qrcm_core

// >>> verif/qrcm_host_model.sv
`timescale 1ns/100ps
module qrcm_host_model (
   input wire logic clk_i,
   input wire logic [3:0] lines_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic [3:0] lines_o,
   output logic [3:0] lines_oe_o
);
   // Half period in reference cycles; the device needs at least 4
   localparam int HALF = 8;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      lines_o = 4'h0;
      lines_oe_o = 4'h0;
   end
   // One link clock, mode 0: change while low, sample at the rise
   task automatic tick(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] s);
      lines_o = d;
      lines_oe_o = oe;
      repeat (HALF) @(posedge clk_i);
      #1 sclk_o = 1'b1;
      s = lines_i;
      repeat (HALF) @(posedge clk_i);
      #1 sclk_o = 1'b0;
   endtask
   task automatic open_frame();
      @(posedge clk_i);
      #1 cs_n_o = 1'b0;
   endtask
   // Shift out nclk groups of w bits, most significant group first
   task automatic send(input logic [31:0] v, input int nclk, input int w);
      logic [3:0] s;
      logic [3:0] m;
      m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
      for (int i = nclk - 1; i >= 0; i--) begin
         tick(4'(v >> (i * w)) & m, m, s);
      end
   endtask
   // Lines released for dummies and data, so host and device never fight
   task automatic recv(input int nclk, input int w, output logic [31:0] v);
      logic [3:0] s;
      v = 32'h0;
      for (int i = 0; i < nclk; i++) begin
         tick(4'h0, 4'h0, s);
         v = (v << w) | ((w == 4) ? {28'h0, s} : {30'h0, s[1:0]});
      end
   endtask
   task automatic close_frame();
      lines_oe_o = 4'h0;
      repeat (HALF) @(posedge clk_i);
      #1 cs_n_o = 1'b1;
      repeat (4 * HALF) @(posedge clk_i);
      // Step off the edge so callers read settled outputs
      #1;
   endtask
endmodule // qrcm_host_model

// >>> verif/qrcm_core_test.sv
`timescale 1ns/100ps
module qrcm_core_test;
   logic ref_clk, sys_rst, qe, mem_valid, mem_rd, mem_ready, cont, cs_n, sclk, oe_seen;
   logic [7:0] mem_data;
   logic [7:0] mode_bits;
   logic [19:0] mem_addr;
   logic [3:0] float_pat, host_o, host_oe, dev_o, dev_oe, lines;
   int err_count, checks_done;

   qrcm_core dut_u (
      .REF_CLK_I(ref_clk), .SYS_RST_I(sys_rst), .SPI_CS_N_I(cs_n), .SPI_SCLK_I(sclk),
      .QUAD_DATA_LINES_I(lines), .QUAD_DATA_LINES_O(dev_o), .QUAD_DATA_LINES_OE_O(dev_oe),
      .QUAD_ENABLE_BIT_I(qe), .MEM_RD_O(mem_rd), .MEM_ADDR_O(mem_addr), .MEM_VALID_I(mem_valid),
      .MEM_DATA_I(mem_data), .MEM_READY_O(mem_ready), .CONT_READ_ACTIVE_O(cont),
      .CONTINUOUS_READ_MODE_BITS_O(mode_bits)
   );
   qrcm_host_model host_u (
      .clk_i(ref_clk), .lines_i(lines), .cs_n_o(cs_n), .sclk_o(sclk),
      .lines_o(host_o), .lines_oe_o(host_oe)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Undriven lines wander, so a stale value can never pass for data
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lines[i] = dev_oe[i] ? dev_o[i] : host_oe[i] ? host_o[i] : float_pat[i];
      end
   end
   always @(posedge ref_clk) begin
      float_pat <= ~float_pat;
      if (dev_oe !== 4'h0) oe_seen <= 1'b1;
   end

   function automatic logic [7:0] mem_byte(input logic [19:0] a);
      return a[7:0] ^ a[15:8] ^ {a[19:16], 4'h9};
   endfunction

   // Array model: random latency, answer held until taken
   initial begin
      logic [19:0] a;
      mem_valid = 1'b0;
      mem_data = 8'h00;
      forever begin
         @(posedge ref_clk);
         if (mem_rd === 1'b1) begin
            a = mem_addr;
            repeat ($urandom_range(2, 0)) @(posedge ref_clk);
            #1 mem_valid = 1'b1;
            mem_data = mem_byte(a);
            do @(posedge ref_clk); while (mem_ready !== 1'b1);
            #1 mem_valid = 1'b0;
            mem_data = ~mem_data;
         end
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("Mismatches: %0d, comparisons: %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // A zero opcode means the opcode is skipped; mclk zero means no mode byte
   task automatic do_read(input logic [7:0] op, input int aw, input int dw,
         input logic [19:0] a, input int mclk, input logic [7:0] m, input int dum,
         input int nb, input int tail, input logic exp);
      logic [31:0] v;
      host_u.open_frame();
      if (op !== 8'h00) host_u.send({24'h0, op}, 8, 1);
      host_u.send({12'h0, a}, 24 / aw, aw);
      if (mclk > 0) host_u.send({24'h0, m}, mclk, aw);
      host_u.recv(dum, 1, v);
      oe_seen = 1'b0;
      for (int i = 0; i < nb; i++) begin
         host_u.recv(8 / dw, dw, v);
         if (exp) check(v, {24'h0, mem_byte(a + 20'(i))});
      end
      host_u.recv(tail, dw, v);
      host_u.close_frame();
      check({31'h0, oe_seen}, {31'h0, exp});
      check({28'h0, dev_oe}, 32'h0);
   endtask

   task automatic mode_reset(input int nclk, input int w);
      host_u.open_frame();
      host_u.send(32'hffffffff, nclk, w);
      host_u.close_frame();
      check({31'h0, cont}, 32'h0);
      check({31'h0, mode_bits[4]}, 32'h1);
   endtask

   initial begin
      int pairs[4];
      logic [7:0] m;
      logic [31:0] seed_v;
      pairs = '{0, 1, 3, 2};
      sys_rst = 1'b1;
      qe = 1'b0;
      float_pat = 4'h5;
      oe_seen = 1'b0;
      err_count = 0;
      checks_done = 0;
      seed_v = $urandom(32'h82bcafd7);
      repeat (8) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      check({31'h0, cont}, 32'h0);
      check({24'h0, mode_bits}, 32'hff);
      #1 qe = 1'b1;
      do_read(8'h6b, 1, 4, 20'($urandom), 0, 8'h00, 8, 6, 1, 1'b1);
      do_read(8'h6b, 1, 4, 20'hffffe, 0, 8'h00, 8, 4, 0, 1'b1);
      #1 qe = 1'b0;
      do_read(8'h6b, 1, 4, 20'($urandom), 0, 8'h00, 8, 2, 0, 1'b0);
      do_read(8'heb, 4, 4, 20'($urandom), 2, 8'h20, 4, 2, 0, 1'b0);
      check({31'h0, cont}, 32'h0);
      #1 qe = 1'b1;
      foreach (pairs[k]) begin
         m = 8'($urandom);
         m[5:4] = 2'(pairs[k]);
         do_read(8'heb, 4, 4, 20'($urandom), 2, m, 4, $urandom_range(5, 1),
            $urandom_range(1, 0), 1'b1);
         check({24'h0, mode_bits}, {24'h0, m});
         check({31'h0, cont}, {31'h0, pairs[k] == 2});
      end
      m[5:4] = 2'h2;
      do_read(8'h00, 4, 4, 20'($urandom), 2, m, 4, 3, 0, 1'b1);
      check({31'h0, cont}, 32'h1);
      m[5:4] = 2'h3;
      do_read(8'h00, 4, 4, 20'($urandom), 2, m, 4, 3, 0, 1'b1);
      check({31'h0, cont}, 32'h0);
      do_read(8'heb, 4, 4, 20'($urandom), 2, 8'h20, 4, 2, 0, 1'b1);
      mode_reset(8, 4);
      do_read(8'hbb, 2, 2, 20'($urandom), 4, 8'ha5, 0, 3, 1, 1'b1);
      check({31'h0, cont}, 32'h1);
      do_read(8'h00, 2, 2, 20'($urandom), 4, 8'h2c, 0, 3, 0, 1'b1);
      mode_reset(16, 2);
      do_read(8'heb, 4, 4, 20'($urandom), 2, 8'h00, 4, 1, 0, 1'b1);
      check({24'h0, mode_bits}, 32'h0);
      mode_reset(8, 1);
      report_and_stop();
   end

   // Whole run is near 7900 reference cycles; allow nearly five times that
   initial begin
      #150000;
      err_count++;
      report_and_stop();
   end
endmodule // qrcm_core_test
